/* dma_setup_pkg.sv */
// Shared constants and types for the DMA channel setup block
package dma_setup_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_CH = 12; // Channel count
    localparam int CH_W = 4; // Channel index width
    localparam int CNT_W = 24; // Count field width
    localparam int CNT_LO_W = 16; // Width of the units-per-sub-block field
    localparam int CNT_HI_LSB = 16; // Sub-block count position
    localparam int REQ_W = 6; // Request type width
    localparam int PERIPH_W = 64; // One line per request code
    // ==========================================================
    // Register map: byte address = ch * 0x20 + index * 4
    localparam logic [2:0] REG_SRC = 3'h0; // Source address
    localparam logic [2:0] REG_TGT = 3'h1; // Target address
    localparam logic [2:0] REG_CNT = 3'h2; // Transfer count
    localparam logic [2:0] REG_REQ = 3'h3; // Request select
    localparam logic [2:0] REG_CTL = 3'h4; // Control and status
    // ==========================================================
    // Control register fields
    localparam int CTL_EN = 0; // Channel enable
    localparam int CTL_STRIDE = 1; // Stride counting
    localparam int CTL_DONE = 2; // Sticky done, write one clears
    localparam int CTL_BUSY = 3; // Read-only activity
    // ==========================================================
    // Reset values
    localparam logic [31:0] RST_ADDR = 32'h0000_0000;
    localparam logic [23:0] RST_CNT = 24'h00_0000;
    localparam logic [5:0] RST_REQ = 6'h00;
    // ==========================================================
    // Request type codes
    localparam logic [5:0] RT_EXT = 6'h00; // External pin request
    localparam logic [5:0] RT_NAND = 6'h01; // NAND path
    localparam logic [5:0] RT_ECC_ENC = 6'h02; // Error-correction encode
    localparam logic [5:0] RT_ECC_DEC = 6'h03; // Error-correction decode
    localparam logic [5:0] RT_RSV_LO = 6'h04; // First reserved code
    localparam logic [5:0] RT_RSV_HI = 6'h07; // Last reserved code
    localparam logic [5:0] RT_AUTO = 6'h08; // Free running
    localparam logic [5:0] RT_TS_RX = 6'h09; // Stream receive FIFO
    localparam logic [5:0] RT_UART_TX = 6'h0E; // Fourth UART transmit
    localparam logic [5:0] RT_UART_RX = 6'h0F; // Fourth UART receive
    // ==========================================================
    // Types
    typedef struct packed {
        logic [CH_W-1:0] chan;
        logic last;
        logic [31:0] src;
        logic [31:0] dst;
    } xfer_type;
    typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_type;
endpackage

/* xfer_if.sv */
// Valid/ready carrier for transfer words between setup logic and buffer
`timescale 1ns/100ps
interface xfer_if;
    import dma_setup_pkg::*;
    logic valid; // Word offered
    logic ready; // Word accepted
    xfer_type data; // Transfer word
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* xfer_buffer.sv */
// Two-entry valid/ready buffer for transfer words
`timescale 1ns/100ps
module xfer_buffer #(
    parameter int DEPTH = 2
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    xfer_if.snk fill,
    xfer_if.src drain
);
    import dma_setup_pkg::*;
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    xfer_type mem_r [DEPTH]; // Entry storage
    logic [PW-1:0] wr_ptr_r; // Next write slot
    logic [PW-1:0] rd_ptr_r; // Oldest entry
    logic [CW-1:0] used_r; // Occupancy
    logic push; // Word enters
    logic pop; // Word leaves
    // ==========================================================
    // Handshakes: full stalls the filler, empty hides the output
    assign fill.ready = (used_r != CW'(DEPTH));
    assign drain.valid = (used_r != '0);
    assign drain.data = mem_r[rd_ptr_r];
    assign push = ce_in & fill.valid & fill.ready;
    assign pop = ce_in & drain.valid & drain.ready;
    // Storage write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
        end else if (push) begin
            mem_r[wr_ptr_r] <= fill.data;
        end
    end
    // Pointers and occupancy
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            used_r <= '0;
        end else begin
            if (push) wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            if (pop) rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            if (push & !pop) used_r <= used_r + 1'b1;
            else if (pop & !push) used_r <= used_r - 1'b1;
        end
    end
endmodule // xfer_buffer

/* dma_channel_setup_regs.sv */
// Per-channel setup registers, request selection and unit issue
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// - twelve channels, each with read/write source address
// - each channel has read/write target address
// - unused count/select high bits read zero
// - plain mode count decrements to zero
// - stride mode: units and sub-blocks count down
// - six-bit request type selects trigger source
// - code zero: pin request, per-channel acknowledge
// - code one selects NAND request
// - codes two, three: encode, decode requests
// - code eight runs freely without request
// - code nine: stream receive FIFO request
// - codes fourteen, fifteen: fourth UART requests
module dma_channel_setup_regs (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [8:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic [dma_setup_pkg::NUM_CH-1:0] EXT_REQUEST_IN,
    output logic [dma_setup_pkg::NUM_CH-1:0] EXT_ACKNOWLEDGE_OUT,
    input wire logic [dma_setup_pkg::PERIPH_W-1:0] PERIPH_REQ_IN,
    output logic XFER_VALID_OUT,
    input wire logic XFER_READY_IN,
    output logic [dma_setup_pkg::CH_W-1:0] XFER_CHAN_OUT,
    output logic XFER_LAST_OUT,
    output logic [31:0] XFER_SRC_OUT,
    output logic [31:0] XFER_DST_OUT
);
    import dma_setup_pkg::*;
    // ==========================================================
    // Declarations
    bus_state_type bus_state_r; // Slave state
    logic [31:0] rd_data_r; // Captured read word
    logic take; // Request taken this cycle
    logic [CH_W-1:0] bus_ch; // Addressed channel
    logic [2:0] bus_reg; // Addressed register
    logic bus_hit; // Mapped address
    logic [31:0] rd_mux; // Read data before capture
    logic [31:0] src_r [NUM_CH]; // Source addresses
    logic [31:0] tgt_r [NUM_CH]; // Target addresses
    logic [CNT_W-1:0] cnt_r [NUM_CH]; // Live counts
    logic [CNT_LO_W-1:0] reload_r [NUM_CH]; // Sub-block size
    logic [REQ_W-1:0] req_r [NUM_CH]; // Request type
    logic [NUM_CH-1:0] en_r; // Enables
    logic [NUM_CH-1:0] stride_r; // Stride mode
    logic [NUM_CH-1:0] done_r; // Sticky done
    logic [NUM_CH-1:0] sy1_r, sy2_r, sy3_r; // Pin synchroniser
    logic [NUM_CH-1:0] ext_lvl_r; // Filtered pin request
    logic [NUM_CH-1:0] active; // Count not exhausted
    logic [NUM_CH-1:0] trig; // Selected source asserted
    logic [NUM_CH-1:0] want; // Ready to issue
    logic [NUM_CH-1:0] grant; // Issued this cycle
    logic [NUM_CH-1:0] last; // Issued unit is the final one
    logic [NUM_CH-1:0] ack_r; // Pin acknowledge pulses
    logic [CH_W-1:0] sel_ch; // Granted channel
    xfer_if fill_if (); // Into buffer
    xfer_if drain_if (); // Out of buffer
    // One clock domain, so every check below shares this clock and reset
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);

    // ==========================================================
    // Wishbone slave: one wait state, unmapped reads give zero
    assign bus_ch = WB_ADR_IN[8:5];
    assign bus_reg = WB_ADR_IN[4:2];
    assign bus_hit = (bus_ch < CH_W'(NUM_CH)) && (bus_reg <= REG_CTL);
    assign take = CE_IN & WB_CYC_IN & WB_STB_IN & (bus_state_r == BUS_IDLE);
    assign WB_ACK_OUT = (bus_state_r == BUS_ACK);
    assign WB_DAT_OUT = rd_data_r;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
        return r;
    endfunction

    // Write strobe for one register of one channel
    function automatic logic wr_hit(input int ch, input logic [2:0] rg);
        return take & WB_WE_IN & bus_hit & (bus_ch == CH_W'(ch)) & (bus_reg == rg);
    endfunction

    // Bus state: ack one cycle, then idle so ack drops next cycle
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            bus_state_r <= BUS_IDLE;
        end else if (CE_IN) begin
            case (bus_state_r)
                BUS_IDLE: if (take) bus_state_r <= BUS_ACK;
                BUS_ACK: bus_state_r <= BUS_IDLE;
                default: bus_state_r <= BUS_IDLE;
            endcase
        end
    end

    // Read mux; high bits of narrow registers stay zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (bus_hit) begin
            case (bus_reg)
                REG_SRC: rd_mux = src_r[bus_ch];
                REG_TGT: rd_mux = tgt_r[bus_ch];
                REG_CNT: rd_mux = {8'h00, cnt_r[bus_ch]};
                REG_REQ: rd_mux = {26'h000_0000, req_r[bus_ch]};
                REG_CTL: begin
                    rd_mux[CTL_EN] = en_r[bus_ch];
                    rd_mux[CTL_STRIDE] = stride_r[bus_ch];
                    rd_mux[CTL_DONE] = done_r[bus_ch];
                    rd_mux[CTL_BUSY] = en_r[bus_ch] & active[bus_ch];
                end
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Read capture at take
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) rd_data_r <= 32'h0000_0000;
        else if (take & !WB_WE_IN) rd_data_r <= rd_mux;
    end

    // ==========================================================
    // Pin request synchroniser: change counts once stages 2 and 3 agree
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sy1_r <= '0;
            sy2_r <= '0;
            sy3_r <= '0;
            ext_lvl_r <= '0;
        end else if (CE_IN) begin
            sy1_r <= EXT_REQUEST_IN;
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            for (int i = 0; i < NUM_CH; i++) if (sy2_r[i] == sy3_r[i]) ext_lvl_r[i] <= sy3_r[i];
        end
    end

    // ==========================================================
    // Per-channel registers and counting
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        logic [REQ_W-1:0] code; // This channel's request type
        logic [CNT_LO_W-1:0] lo; // Units left in sub-block
        logic [7:0] hi; // Sub-blocks left
        logic [CNT_W-1:0] cnt_nxt; // Count after one unit
        logic cnt_we; // Count written this cycle
        logic [31:0] cnt_wd; // Count word after byte merge
        logic [31:0] req_wd; // Select word after byte merge
        // Write strobe as a real signal, so checks see its sampled value
        always_comb cnt_we = wr_hit(g, REG_CNT);
        assign cnt_wd = merge({8'h00, cnt_r[g]}, WB_DAT_IN, WB_SEL_IN);
        assign req_wd = merge({26'h000_0000, req_r[g]}, WB_DAT_IN, WB_SEL_IN);
        assign code = req_r[g];
        assign lo = cnt_r[g][CNT_LO_W-1:0];
        assign hi = cnt_r[g][CNT_W-1:CNT_HI_LSB];
        // Stride mode counts on the low part only while it is non-zero
        assign active[g] = stride_r[g] ? (lo != '0) : (cnt_r[g] != '0);
        assign last[g] = stride_r[g] ? (lo == 16'h0001 && hi <= 8'h01)
                                     : (cnt_r[g] == 24'h00_0001);

        // Trigger decode; reserved codes fall to the default and never fire
        always_comb begin
            case (code)
                RT_EXT: trig[g] = ext_lvl_r[g];
                RT_AUTO: trig[g] = 1'b1;
                RT_NAND, RT_ECC_ENC, RT_ECC_DEC: trig[g] = PERIPH_REQ_IN[code];
                RT_TS_RX: trig[g] = PERIPH_REQ_IN[code];
                RT_UART_TX, RT_UART_RX: trig[g] = PERIPH_REQ_IN[code];
                default: trig[g] = (code > RT_AUTO) & PERIPH_REQ_IN[code];
            endcase
        end
        assign want[g] = en_r[g] & active[g] & trig[g];

        // Next count: plain decrement, or stride with sub-block reload
        always_comb begin
            if (!stride_r[g]) cnt_nxt = cnt_r[g] - 24'h00_0001;
            else if (lo != 16'h0001) cnt_nxt = {hi, lo - 16'h0001};
            else if (hi > 8'h01) cnt_nxt = {hi - 8'h01, reload_r[g]};
            else cnt_nxt = RST_CNT;
        end

        // Addresses: software owned
        always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
            if (RST_IN) begin
                src_r[g] <= RST_ADDR;
                tgt_r[g] <= RST_ADDR;
            end else begin
                if (wr_hit(g, REG_SRC)) src_r[g] <= merge(src_r[g], WB_DAT_IN, WB_SEL_IN);
                if (wr_hit(g, REG_TGT)) tgt_r[g] <= merge(tgt_r[g], WB_DAT_IN, WB_SEL_IN);
            end
        end

        // Count and request type; a software write beats a decrement
        always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
            if (RST_IN) begin
                cnt_r[g] <= RST_CNT;
                reload_r[g] <= RST_CNT[CNT_LO_W-1:0];
                req_r[g] <= RST_REQ;
            end else if (CE_IN) begin
                if (cnt_we) begin
                    cnt_r[g] <= cnt_wd[CNT_W-1:0];
                    reload_r[g] <= cnt_wd[CNT_LO_W-1:0];
                end else if (grant[g]) begin
                    cnt_r[g] <= cnt_nxt;
                end
                if (wr_hit(g, REG_REQ))
                    req_r[g] <= req_wd[REQ_W-1:0];
            end
        end

        // Control; done set by the last unit wins over a clear
        always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
            if (RST_IN) begin
                en_r[g] <= 1'b0;
                stride_r[g] <= 1'b0;
                done_r[g] <= 1'b0;
            end else if (CE_IN) begin
                if (wr_hit(g, REG_CTL) && WB_SEL_IN[0]) begin
                    en_r[g] <= WB_DAT_IN[CTL_EN];
                    stride_r[g] <= WB_DAT_IN[CTL_STRIDE];
                end
                if (grant[g] && last[g]) done_r[g] <= 1'b1;
                else if (wr_hit(g, REG_CTL) && WB_SEL_IN[0] && WB_DAT_IN[CTL_DONE])
                    done_r[g] <= 1'b0;
            end
        end

        // Plain mode: each unit takes exactly one off the count
        count_step_a: assert property (CE_IN && grant[g] && !stride_r[g]
            && !cnt_we |=> cnt_r[g] == $past(cnt_r[g]) - 24'h00_0001)
            else $error("count did not step by one");
        // Stride mode: end of sub-block reloads its unit count
        stride_reload_a: assert property (CE_IN && grant[g] && stride_r[g]
            && lo == 16'h0001 && hi > 8'h01 && !cnt_we
            |=> cnt_r[g][CNT_LO_W-1:0] == reload_r[g])
            else $error("sub-block did not reload");
        // Nothing issues once the count is spent, and the count never wraps
        zero_stop_a: assert property (!active[g] && !cnt_we |-> !grant[g] ##1 !active[g])
            else $error("count moved after reaching zero");
        // Reserved codes never win
        reserved_code_a: assert property (grant[g]
            |-> !(code >= RT_RSV_LO && code <= RT_RSV_HI))
            else $error("reserved request code issued");
        // Each pin unit is answered by an acknowledge the next cycle
        pin_ack_a: assert property (CE_IN && grant[g] && code == RT_EXT
            |=> EXT_ACKNOWLEDGE_OUT[g])
            else $error("acknowledge missing after pin unit");
        // No acknowledge without a pin unit behind it
        ack_quiet_a: assert property (CE_IN && !(grant[g] && code == RT_EXT)
            |=> !EXT_ACKNOWLEDGE_OUT[g])
            else $error("acknowledge without pin unit");
        // An enabled free running channel with count and buffer room left means some channel issues
        auto_run_a: assert property (CE_IN && en_r[g] && active[g] && code == RT_AUTO
            && fill_if.ready |-> grant != '0)
            else $error("auto channel idle with work left");
    end

    // ==========================================================
    // Fixed priority: lowest channel first, stalled by a full buffer
    always_comb begin
        grant = '0;
        sel_ch = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (want[i]) sel_ch = CH_W'(i);
        end
        if (CE_IN && fill_if.ready && want != '0) grant[sel_ch] = 1'b1;
    end

    // Issue word: current addresses, channel and final marker
    assign fill_if.valid = CE_IN && want != '0;
    assign fill_if.data = '{chan: sel_ch, last: last[sel_ch], src: src_r[sel_ch],
                            dst: tgt_r[sel_ch]};

    // Acknowledge pulse for pin-paced channels
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) ack_r <= '0;
        else if (CE_IN) begin
            for (int i = 0; i < NUM_CH; i++) ack_r[i] <= grant[i] & (req_r[i] == RT_EXT);
        end
    end
    assign EXT_ACKNOWLEDGE_OUT = ack_r;

    // ==========================================================
    // Two-entry buffer so a stalled engine loses no word
    xfer_buffer #(.DEPTH(2)) u_buf (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .fill(fill_if),
        .drain(drain_if)
    );
    assign drain_if.ready = XFER_READY_IN;
    assign XFER_VALID_OUT = drain_if.valid;
    assign XFER_CHAN_OUT = drain_if.data.chan;
    assign XFER_LAST_OUT = drain_if.data.last;
    assign XFER_SRC_OUT = drain_if.data.src;
    assign XFER_DST_OUT = drain_if.data.dst;

    // ==========================================================
    // Bus checks
    sequence bus_take_s;
        take;
    endsequence
    sequence ack_pulse_s;
        WB_ACK_OUT ##1 !WB_ACK_OUT;
    endsequence
    bus_ack_a: assert property (bus_take_s ##1 CE_IN |-> ack_pulse_s)
        else $error("ack not one cycle after take");
    cnt_high_zero_a: assert property (take && !WB_WE_IN && bus_hit
        && bus_reg == REG_CNT |=> WB_DAT_OUT[31:24] == 8'h00)
        else $error("count high bits not zero");
    req_high_zero_a: assert property (take && !WB_WE_IN && bus_hit
        && bus_reg == REG_REQ |=> WB_DAT_OUT[31:6] == 26'h000_0000)
        else $error("select high bits not zero");
    src_readback_a: assert property (take && !WB_WE_IN && bus_hit
        && bus_reg == REG_SRC |=> WB_DAT_OUT == $past(src_r[bus_ch]))
        else $error("source readback mismatch");
endmodule // dma_channel_setup_regs

/* peripheral_model.sv */
// Far-side model: request sources and a stalling transfer sink
`timescale 1ns/100ps
module peripheral_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [6:0] code_in, // Bit 6 high: no line raised
    input wire logic [11:0] ext_in, // Pin requests wanted
    input wire logic hold_in, // Stall the sink outright
    input wire logic valid_in,
    input wire logic last_in,
    input wire logic [11:0] ack_in,
    output logic [11:0] ext_out,
    output logic [63:0] periph_out,
    output logic ready_out
);
    int n_take; // Words taken
    int n_last; // Final units seen
    int n_ack; // Pin acknowledges seen
    logic [1:0] ph_r; // Stall phase
    // ==========================================================
    // Request lines are levels, one line per code
    always_comb begin
        ext_out = ext_in;
        periph_out = code_in[6] ? 64'h0 : (64'h1 << code_in[5:0]);
    end
    // ==========================================================
    // Sink stalls one cycle in three so the buffer sees back-pressure
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ph_r <= 2'h0;
            ready_out <= 1'b0;
            n_take <= 0;
            n_last <= 0;
            n_ack <= 0;
        end else begin
            ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
            ready_out <= !hold_in && ph_r != 2'h2;
            if (valid_in && ready_out) begin
                n_take <= n_take + 1;
                n_last <= n_last + int'(last_in);
            end
            n_ack <= n_ack + $countones(ack_in);
        end
    end
endmodule // peripheral_model

/* testbench.sv */
// Self-checking bench for the DMA channel setup registers
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
    import dma_setup_pkg::*;
    logic clk, rst, ce, cyc, stb, we, ack, hold, valid, ready, last;
    logic [3:0] xchan, lchan;
    logic [31:0] xsrc, xdst, lsrc, ldst;
    logic [8:0] adr;
    logic [31:0] dw, dr, q;
    logic [11:0] ext_want, ext, eack;
    logic [63:0] periph;
    logic [6:0] code;
    int n_mismatch, checked, base, j;
    logic [5:0] codes [6] = '{6'h01, 6'h02, 6'h03, 6'h09, 6'h0E, 6'h0F};
    dma_channel_setup_regs i_dma_channel_setup_regs (.SYS_CLK_IN(clk), .RST_IN(rst),
        .CE_IN(ce), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
        .WB_SEL_IN(4'hF), .WB_DAT_IN(dw), .WB_DAT_OUT(dr), .WB_ACK_OUT(ack),
        .EXT_REQUEST_IN(ext), .EXT_ACKNOWLEDGE_OUT(eack), .PERIPH_REQ_IN(periph),
        .XFER_VALID_OUT(valid), .XFER_READY_IN(ready), .XFER_CHAN_OUT(xchan),
        .XFER_LAST_OUT(last), .XFER_SRC_OUT(xsrc), .XFER_DST_OUT(xdst));
    peripheral_model i_peripheral_model (.clk_in(clk), .rst_in(rst), .code_in(code),
        .ext_in(ext_want), .hold_in(hold), .valid_in(valid), .last_in(last),
        .ack_in(eack), .ext_out(ext), .periph_out(periph), .ready_out(ready));
    // Fields of the last word the sink took
    always @(posedge clk) begin
        if (valid && ready) begin
            lchan <= xchan;
            lsrc <= xsrc;
            ldst <= xdst;
        end
    end
    // ==========================================================
    // Verdict and end of run
    task automatic complete_run;
        if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [8:0] ra(input int ch, input logic [2:0] idx);
        return 9'(ch * 32 + int'(idx) * 4);
    endfunction
    // ==========================================================
    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d;
        do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
        q = dr;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (k >= 50) begin n_mismatch++; complete_run(); end
    endtask
    task automatic rd_chk(input logic [8:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %0h", a), e, q)
    endtask
    // Load count, then control; words counted from here
    task automatic go(input int ch, input logic [31:0] cnt, input logic [31:0] ctl);
        base = i_peripheral_model.n_take;
        wb(1'b1, ra(ch, REG_CNT), cnt);
        wb(1'b1, ra(ch, REG_CTL), ctl);
    endtask
    // Bounded wait for n words, a short settle to catch extras, then disable
    task automatic await(input int ch, input int n);
        int k;
        k = 0;
        while (i_peripheral_model.n_take < base + n && k < 2000) begin
            @(posedge clk); k++;
        end
        if (k >= 2000) begin n_mismatch++; complete_run(); end
        repeat (8) @(posedge clk);
        `CHK("words", base + n, i_peripheral_model.n_take)
        wb(1'b1, ra(ch, REG_CTL), 32'h0);
    endtask
    // ==========================================================
    // Clock generation
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 9'h000; dw = 32'h0;
        ext_want = 12'h000; code = 7'h40; hold = 1'b0; n_mismatch = 0; checked = 0; ce = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (j = 0; j < 4; j++) rd_chk(ra(0, 3'(j)), 32'h0);
        wb(1'b1, ra(11, REG_SRC), 32'hA5A5_5A5A);
        wb(1'b1, ra(11, REG_TGT), 32'h3C3C_C3C3);
        rd_chk(ra(11, REG_SRC), 32'hA5A5_5A5A);
        rd_chk(ra(11, REG_TGT), 32'h3C3C_C3C3);
        wb(1'b1, ra(3, REG_CNT), 32'hFFFF_FFFF);
        wb(1'b1, ra(3, REG_REQ), 32'hFFFF_FFFF);
        rd_chk(ra(3, REG_CNT), 32'h00FF_FFFF);
        rd_chk(ra(3, REG_REQ), 32'h0000_003F);
        rd_chk(ra(12, REG_SRC), 32'h0);
        // Auto request against a full buffer, then drained
        hold <= 1'b1;
        wb(1'b1, ra(0, REG_REQ), 32'(RT_AUTO));
        go(0, 32'h5, 32'h1);
        repeat (12) @(posedge clk);
        rd_chk(ra(0, REG_CNT), 32'h3);
        hold <= 1'b0;
        await(0, 5);
        rd_chk(ra(0, REG_CNT), 32'h0);
        // Stride: two sub-blocks of two units
        wb(1'b1, ra(5, REG_REQ), 32'(RT_AUTO));
        go(5, 32'h0002_0002, 32'h3);
        await(5, 4);
        rd_chk(ra(5, REG_CNT), 32'h0);
        // Reserved codes raise their line yet move nothing
        for (j = 4; j < 8; j++) begin
            wb(1'b1, ra(1, REG_REQ), 32'(j));
            code <= 7'(j);
            go(1, 32'h2, 32'h1);
            await(1, 0);
            rd_chk(ra(1, REG_CNT), 32'h2);
        end
        // Each on-chip source moves one unit
        for (j = 0; j < 6; j++) begin
            wb(1'b1, ra(j + 6, REG_REQ), 32'(codes[j]));
            code <= {1'b0, codes[j]};
            go(j + 6, 32'h1, 32'h1);
            await(j + 6, 1);
            rd_chk(ra(j + 6, REG_CNT), 32'h0);
        end
        // Last word came from channel eleven with its programmed addresses
        `CHK("chan", 4'hB, lchan)
        `CHK("src", 32'hA5A5_5A5A, lsrc)
        `CHK("dst", 32'h3C3C_C3C3, ldst)
        code <= 7'h40;
        // Pin request with acknowledge pulses; a pulse while frozen is never seen
        j = i_peripheral_model.n_ack;
        wb(1'b1, ra(2, REG_REQ), 32'(RT_EXT));
        go(2, 32'h2, 32'h1);
        ce <= 1'b0;
        ext_want <= 12'h004;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        ext_want <= 12'h000;
        repeat (10) @(posedge clk);
        rd_chk(ra(2, REG_CNT), 32'h2);
        ext_want <= 12'h004;
        await(2, 2);
        ext_want <= 12'h000;
        `CHK("acks", j + 2, i_peripheral_model.n_ack)
        `CHK("lasts", 9, i_peripheral_model.n_last)
        complete_run();
    end
endmodule // testbench
